// ---- core/data_space_address_decode.v ----
// Data space address decode: read/write AGUs, paging, lanes, trap.
// Operation
// - Every 16-bit data address is a byte address in a linear 64 Kbyte space.
// - Separate read and write address generation units.
// - 0x0000 to 0x7FFF map directly, no page register involved.
// - 0x8000 to 0xFFFF form the window into extended data space.
// - Pages are 32 Kbytes; read page for reads, write page for writes.
// - Program memory reads through the window use only the read page.
// - Window access combines page with address into a 24-bit effective address.
// - Internal RAM above 30 Kbytes is reachable only through the window.
// - External memory up to 4 MB, pages 80h to FFh, is mapped behind the window.
// - Low byte at even address, high byte at odd address.
// - Post-modify step is one for byte, two for word operations.
// - Byte read fetches the word; address bit zero picks byte onto low lane.
// - Shared word decode, separate byte strobes; byte write touches one lane.
// - Odd-address word access raises an address error trap.
// - Misaligned read completes, misaligned write suppressed; trap rises with the read strobe.
// - Byte load into a working register keeps its high byte.
// - Sign-extend and zero-extend of a byte to 16 bits.
// - Near region 0000h-1FFFh reached by a 13-bit absolute field.
// - Move instructions address the whole space with a 16-bit field.
// - 0000h to 07FFh decode to control registers.
// - Unimplemented control register addresses read as zero.
// - Control register region decoded in 32-byte module blocks.
`timescale 1ns/1ps
`include "ds_decode_defines.vh"
module data_space_address_decode (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Read address request from the core
    input  wire        rd_req,
    input  wire        rd_word,
    input  wire        rd_near,
    input  wire [15:0] rd_addr,
    input  wire        rd_postinc,
    // Write address request from the core
    input  wire        wr_req,
    input  wire        wr_word,
    input  wire        wr_near,
    input  wire [15:0] wr_addr,
    input  wire [15:0] wr_data,
    input  wire        wr_postinc,
    // Read data return from memories
    input  wire [15:0] mem_rdata,
    // Working register byte merge and extend
    input  wire [15:0] wreg_old,
    input  wire        ext_sign,
    input  wire        ext_zero,
    // Read port to memories
    output reg         mem_rd,
    output reg  [23:0] mem_rd_addr,
    output reg  [2:0]  mem_rd_region,
    // Write port to memories
    output reg         mem_wr,
    output reg  [23:0] mem_wr_addr,
    output reg  [2:0]  mem_wr_region,
    output reg  [1:0]  mem_wr_lane,
    output reg  [15:0] mem_wdata,
    // Read data to the core
    output reg  [15:0] rd_data,
    output reg  [15:0] wreg_new,
    // Pointer updates
    output reg  [15:0] rd_ptr_next,
    output reg  [15:0] wr_ptr_next,
    // Page registers and trap
    output reg  [8:0]  window_read_page_reg,
    output reg  [8:0]  window_write_page_reg,
    output reg         addr_error_trap
);
    wire [15:0] rd_full;
    wire [15:0] wr_full;
    wire [23:0] rd_ea;
    wire [23:0] wr_ea;
    wire [2:0]  rd_region;
    wire [2:0]  wr_region;
    wire        rd_mis;
    wire        wr_mis;
    wire [1:0]  rd_lanes;
    wire [1:0]  wr_lanes;
    wire        page_rd_hit;
    wire        page_wr_hit;
    reg         rd_sel_hi;
    reg         rd_is_byte;
    reg         rd_sfr_none;
    reg  [7:0]  sel_byte;
    reg  [15:0] next_rd_data;
    reg  [15:0] next_wreg;
    reg  [15:0] next_rd_ptr;
    reg  [15:0] next_wr_ptr;
    wire [15:0] next_wdata;
    wire        page_hi_bit;

    // Near instructions carry a 13-bit field; moves carry all 16 bits.
    assign rd_full = rd_near ? {3'h0, rd_addr[`NEAR_FIELD_W-1:0]} : rd_addr;
    assign wr_full = wr_near ? {3'h0, wr_addr[`NEAR_FIELD_W-1:0]} : wr_addr;

    // Two independent units, each with its own page register.
    ds_agu u_rd_agu (
        .addr       (rd_full),
        .word_op    (rd_word),
        .page       (window_read_page_reg),
        .eff_addr   (rd_ea),
        .region     (rd_region),
        .misaligned (rd_mis),
        .lane_en    (rd_lanes)
    );

    // Write page never reaches the read path, including program reads.
    ds_agu u_wr_agu (
        .addr       (wr_full),
        .word_op    (wr_word),
        .page       (window_write_page_reg),
        .eff_addr   (wr_ea),
        .region     (wr_region),
        .misaligned (wr_mis),
        .lane_en    (wr_lanes)
    );

    // Page registers live in the control register region and are written here.
    assign page_rd_hit = wr_req & ~wr_mis & ~wr_full[`WINDOW_BIT]
                         & ({wr_full[15:1], 1'b0} == `REG_READ_PAGE);
    assign page_wr_hit = wr_req & ~wr_mis & ~wr_full[`WINDOW_BIT]
                         & ({wr_full[15:1], 1'b0} == `REG_WRITE_PAGE);

    // A byte write to the odd address carries its byte on the low half of the data.
    assign page_hi_bit = wr_word ? wr_data[`PSV_PAGE_BIT] : wr_data[0];

    always @(posedge mclk) begin
        if (!rst_n) begin
            window_read_page_reg <= `PAGE_RESET;
        end else if (page_rd_hit) begin
            if (wr_lanes[0])
                window_read_page_reg[7:0] <= wr_data[7:0];
            if (wr_lanes[1])
                window_read_page_reg[`PSV_PAGE_BIT] <= page_hi_bit;
        end
    end

    // The write page has no program space bit, so only its low byte is writable.
    always @(posedge mclk) begin
        if (!rst_n) begin
            window_write_page_reg <= `PAGE_RESET;
        end else if (page_wr_hit && wr_lanes[0]) begin
            window_write_page_reg[7:0] <= wr_data[7:0];
        end
    end

    // Read request port: a misaligned read still goes out and completes.
    always @(posedge mclk) begin
        if (!rst_n) begin
            mem_rd        <= 1'b0;
            mem_rd_addr   <= 24'h000000;
            mem_rd_region <= `REGION_NONE;
        end else begin
            mem_rd        <= rd_req;
            mem_rd_addr   <= {rd_ea[23:1], 1'b0};
            mem_rd_region <= rd_region;
        end
    end

    // Byte selection state travels with the read to its return cycle.
    always @(posedge mclk) begin
        if (!rst_n) begin
            rd_sel_hi   <= 1'b0;
            rd_is_byte  <= 1'b0;
            rd_sfr_none <= 1'b0;
        end else begin
            rd_sel_hi   <= rd_full[0];
            rd_is_byte  <= ~rd_word;
            rd_sfr_none <= (rd_region == `REGION_NONE);
        end
    end

    // Write request port: a misaligned or unmapped write is dropped.
    always @(posedge mclk) begin
        if (!rst_n) begin
            mem_wr        <= 1'b0;
            mem_wr_addr   <= 24'h000000;
            mem_wr_region <= `REGION_NONE;
            mem_wr_lane   <= 2'h0;
            mem_wdata     <= 16'h0000;
        end else begin
            mem_wr        <= wr_req & ~wr_mis & (wr_region != `REGION_NONE);
            mem_wr_addr   <= {wr_ea[23:1], 1'b0};
            mem_wr_region <= wr_region;
            mem_wr_lane   <= wr_req ? wr_lanes : 2'h0;
            mem_wdata     <= next_wdata;
        end
    end

    // Each lane takes its own byte on a word write and the low byte on a byte
    // write, so whichever strobe is raised finds the byte on its own lane.
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
            assign next_wdata[lane*8 +: 8] = wr_word ? wr_data[lane*8 +: 8]
                                                     : wr_data[7:0];
        end
    endgenerate

    // Read data steering: the chosen byte lands on the low lane.
    always @* begin
        sel_byte = rd_sel_hi ? mem_rdata[15:8] : mem_rdata[7:0];
        if (rd_sfr_none)
            next_rd_data = 16'h0000;
        else if (rd_is_byte)
            next_rd_data = {8'h00, sel_byte};
        else
            next_rd_data = mem_rdata;
    end

    // Working register merge and extend; extend requests take priority.
    always @* begin
        if (ext_sign)
            next_wreg = {{8{wreg_old[7]}}, wreg_old[7:0]};
        else if (ext_zero)
            next_wreg = {8'h00, wreg_old[7:0]};
        else if (rd_is_byte)
            next_wreg = {wreg_old[15:8], next_rd_data[7:0]};
        else
            next_wreg = next_rd_data;
    end

    // Pointer step scales with operand size.
    always @* begin
        if (rd_postinc) begin
            if (rd_word)
                next_rd_ptr = rd_addr + `STEP_WORD;
            else
                next_rd_ptr = rd_addr + `STEP_BYTE;
        end else begin
            next_rd_ptr = rd_addr;
        end
        if (wr_postinc) begin
            if (wr_word)
                next_wr_ptr = wr_addr + `STEP_WORD;
            else
                next_wr_ptr = wr_addr + `STEP_BYTE;
        end else begin
            next_wr_ptr = wr_addr;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            rd_data  <= 16'h0000;
            wreg_new <= 16'h0000;
        end else begin
            rd_data  <= next_rd_data;
            wreg_new <= next_wreg;
        end
    end

    // Pointers keep their last value while no request is made.
    always @(posedge mclk) begin
        if (!rst_n) begin
            rd_ptr_next <= 16'h0000;
            wr_ptr_next <= 16'h0000;
        end else begin
            if (rd_req)
                rd_ptr_next <= next_rd_ptr;
            if (wr_req)
                wr_ptr_next <= next_wr_ptr;
        end
    end

    // Trap follows the access by one cycle, in the same cycle as the read strobe and the
    // dropped write, one cycle before read data is registered, so prior state is still there.
    always @(posedge mclk) begin
        if (!rst_n)
            addr_error_trap <= 1'b0;
        else
            addr_error_trap <= (rd_req & rd_mis) | (wr_req & wr_mis);
    end
endmodule // data_space_address_decode

// ---- core/ds_agu.v ----
// One address generation unit: region decode, window paging, lane select.
`timescale 1ns/1ps
`include "ds_decode_defines.vh"
module ds_agu (
    // Request
    input  wire [15:0] addr,
    input  wire        word_op,
    input  wire [8:0]  page,
    // Result
    output wire [23:0] eff_addr,
    output reg  [2:0]  region,
    output wire        misaligned,
    output wire [1:0]  lane_en
);
    localparam [63:0] SFR_MAP = `SFR_BLOCK_MAP;
    wire in_window = addr[`WINDOW_BIT];
    wire sfr_hit;

    // Window addresses append the page; lower half maps straight.
    assign eff_addr = in_window ? {page[7:0], addr} : {8'h00, addr};
    assign sfr_hit  = SFR_MAP[addr[10:`SFR_BLOCK_LSB]];
    // Odd word address is an error, in either half.
    assign misaligned = word_op & addr[0];
    // Byte lanes: even address is low byte, odd is high byte.
    assign lane_en = word_op ? 2'h3 : (addr[0] ? 2'h2 : 2'h1);

    always @* begin
        if (!in_window) begin
            if (addr <= `SFR_TOP)
                region = sfr_hit ? `REGION_SFR : `REGION_NONE;
            else if (addr <= `INT_RAM_DIRECT_TOP)
                region = `REGION_RAM;
            else
                region = `REGION_NONE;
        end else if (page[`PSV_PAGE_BIT]) begin
            region = `REGION_PROG;
        end else if (page[`EXT_PAGE_BIT]) begin
            region = `REGION_EXT_MEM;
        end else if (page == {`PAGE_W{1'b0}}) begin
            region = `REGION_NONE;
        end else begin
            region = `REGION_INT_EXT;
        end
    end
endmodule // ds_agu

// ---- core/ds_decode_defines.vh ----
// Constants for the data space address decode block.
`ifndef DS_DECODE_DEFINES_VH
`define DS_DECODE_DEFINES_VH
`define WINDOW_BIT          15
`define LOWER_TOP           16'h7FFF
`define NEAR_TOP            16'h1FFF
`define NEAR_FIELD_W        13
`define SFR_TOP             16'h07FF
`define SFR_BLOCK_LSB       5
`define SFR_BLOCK_COUNT     64
`define INT_RAM_DIRECT_TOP  16'h77FF
`define PAGE_W              9
`define PAGE_RESET          9'h001
`define PSV_PAGE_BIT        8
`define EXT_PAGE_BIT        7
`define REG_READ_PAGE       16'h0032
`define REG_WRITE_PAGE      16'h0034
`define STEP_BYTE           16'h0001
`define STEP_WORD           16'h0002
`define REGION_SFR          3'h0
`define REGION_RAM          3'h1
`define REGION_INT_EXT      3'h2
`define REGION_EXT_MEM      3'h3
`define REGION_PROG         3'h4
`define REGION_NONE         3'h5
`define SFR_BLOCK_MAP       64'h00F0_00FE_FF3F_FF7B
`endif

// ---- tb/ds_decode_asserts.sv ----
// Port assertions for the data space address decode block.
`timescale 1ns/1ps
`include "ds_decode_defines.vh"
module ds_decode_asserts (
    // Requests and returns
    input wire        mclk, rst_n, rd_req, rd_word, rd_postinc, wr_req, wr_word,
    input wire        wr_postinc, mem_rd, mem_wr, addr_error_trap,
    input wire [15:0] rd_addr, wr_addr, mem_rdata, rd_data, rd_ptr_next, wr_ptr_next,
    input wire [23:0] mem_rd_addr, mem_wr_addr,
    input wire [2:0]  mem_rd_region,
    input wire [1:0]  mem_wr_lane,
    input wire [8:0]  window_read_page_reg, window_write_page_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire odd_rd = rd_req && rd_word && rd_addr[0];
    wire odd_wr = wr_req && wr_word && wr_addr[0];
    rd_strobe_a: assert property (mem_rd == $past(rd_req))
        else $error("read strobe");
    direct_addr_a: assert property (rd_req && !rd_addr[15] |=>
        mem_rd_addr == {8'h00, $past(rd_addr[15:1]), 1'b0}) else $error("direct address");
    window_read_a: assert property (rd_req && rd_addr[15] |=> mem_rd_addr ==
        {$past(window_read_page_reg[7:0]), $past(rd_addr[15:1]), 1'b0}) else $error("read page");
    window_write_a: assert property (wr_req && wr_addr[15] |=> !mem_wr || mem_wr_addr ==
        {$past(window_write_page_reg[7:0]), $past(wr_addr[15:1]), 1'b0}) else $error("write page");
    prog_region_a: assert property (rd_req && rd_addr[15] && window_read_page_reg[8] |=>
        mem_rd_region == `REGION_PROG) else $error("program region");
    odd_trap_a: assert property (addr_error_trap == $past(odd_rd || odd_wr))
        else $error("trap");
    write_kill_a: assert property (odd_wr |=> !mem_wr) else $error("odd write");
    gap_write_a: assert property (wr_req && !wr_addr[15] && wr_addr > `INT_RAM_DIRECT_TOP
        |=> !mem_wr) else $error("gap write");
    byte_lane_a: assert property (wr_req && !wr_word |=> !mem_wr ||
        mem_wr_lane == ($past(wr_addr[0]) ? 2'b10 : 2'b01)) else $error("byte lane");
    byte_read_a: assert property (rd_req && !rd_word ##1 mem_rd_region == `REGION_RAM |=>
        rd_data == {8'h00, $past(rd_addr[0], 2) ? $past(mem_rdata[15:8]) : $past(mem_rdata[7:0])})
        else $error("byte read");
    post_step_a: assert property (rd_req && rd_postinc |=> rd_ptr_next ==
        $past(rd_addr) + ($past(rd_word) ? 16'h0002 : 16'h0001)) else $error("post step");
    write_step_a: assert property (wr_req && wr_postinc |=> wr_ptr_next ==
        $past(wr_addr) + ($past(wr_word) ? 16'h0002 : 16'h0001)) else $error("write step");
endmodule // ds_decode_asserts
bind data_space_address_decode ds_decode_asserts u_asserts (
    .mclk(mclk), .rst_n(rst_n), .rd_req(rd_req), .rd_word(rd_word), .rd_postinc(rd_postinc),
    .wr_req(wr_req), .wr_word(wr_word), .wr_postinc(wr_postinc), .wr_ptr_next(wr_ptr_next),
    .mem_rd(mem_rd), .mem_wr(mem_wr),
    .addr_error_trap(addr_error_trap), .rd_addr(rd_addr), .wr_addr(wr_addr),
    .mem_rdata(mem_rdata), .rd_data(rd_data), .rd_ptr_next(rd_ptr_next),
    .mem_rd_addr(mem_rd_addr), .mem_wr_addr(mem_wr_addr), .mem_rd_region(mem_rd_region),
    .mem_wr_lane(mem_wr_lane), .window_read_page_reg(window_read_page_reg),
    .window_write_page_reg(window_write_page_reg));

// ---- tb/mem_model.sv ----
// Behavioural memory that answers the read port of the decode block.
`timescale 1ns/1ps
module mem_model (
    // Read port
    input  wire        mclk,
    input  wire        mem_rd,
    input  wire [23:0] mem_rd_addr,
    // Return data
    output reg  [15:0] mem_rdata
);
    reg [15:0] last = 16'h0000;
    // Outside a read the bus shows the inverse of the last word, so stale data never matches.
    always @* mem_rdata = mem_rd ? mem_rd_addr[15:0] ^ {mem_rd_addr[23:16], 8'hC3} : ~last;
    always @(posedge mclk) if (mem_rd) last <= mem_rdata;
endmodule // mem_model

// ---- tb/tb.sv ----
// Self-checking bench for the data space address decode block.
`timescale 1ns/1ps
`include "ds_decode_defines.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
    reg mclk = 0, rst_n = 0, rd_req = 0, rd_word = 0, rd_near = 0, rd_postinc = 0;
    reg wr_req = 0, wr_word = 0, wr_near = 0, wr_postinc = 0, ext_sign = 0, ext_zero = 0;
    reg [15:0] rd_addr = 16'h0000, wr_addr = 16'h0000, wr_data = 16'h0000, wreg_old = 16'h0000;
    wire mem_rd, mem_wr, addr_error_trap;
    wire [15:0] mem_rdata, mem_wdata, rd_data, wreg_new, rd_ptr_next, wr_ptr_next;
    wire [23:0] mem_rd_addr, mem_wr_addr;
    wire [2:0] mem_rd_region, mem_wr_region;
    wire [1:0] mem_wr_lane;
    wire [8:0] window_read_page_reg, window_write_page_reg;
    int errors = 0, num_checks = 0, cycles = 0, seed;
    reg [44:0] rq[$], n;
    reg [17:0] dq[$], d;
    reg [46:0] wq[$], m;
    reg rd_s1 = 0, rd_s2 = 0, wr_s1 = 0, rw, ww;
    reg [15:0] ra, wa;
    reg [8:0] rpg = 9'h001, wpg = 9'h001;
    localparam [63:0] SFR_MAP = `SFR_BLOCK_MAP;
    reg [16:0] rt [0:7] = '{17'h10800, 17'h00801, 17'h00800, 17'h177FE,
                            17'h10040, 17'h10000, 17'h08001, 17'h18003};
    reg [16:0] wt [0:7] = '{17'h00801, 17'h00800, 17'h10802, 17'h10803,
                            17'h07800, 17'h08005, 17'h17FFE, 17'h1FFFE};
    reg [8:0] pt [0:2] = '{9'h002, 9'h080, 9'h100};
    data_space_address_decode dut (.*);
    mem_model u_mem (.mclk(mclk), .mem_rd(mem_rd), .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata));
    always #4 mclk = ~mclk;
    function [26:0] dec(input [15:0] a, input [8:0] pg);
        dec[23:0] = {a[15] ? pg[7:0] : 8'h00, a[15:1], 1'b0};
        dec[26:24] = a[15] ? (pg[8] ? 3'h4 : pg[7] ? 3'h3 : pg != 0 ? 3'h2 : 3'h5)
                   : a <= `SFR_TOP ? (SFR_MAP[a[10:5]] ? 3'h0 : 3'h5)
                   : a <= `INT_RAM_DIRECT_TOP ? 3'h1 : 3'h5;
    endfunction
    task op(input r, input [15:0] a, input w1, input w, input [15:0] b, input w2, input [15:0] wd);
        reg [23:0] ea;
        reg [2:0] rg;
        reg [15:0] v;
        @(posedge mclk);
        #1;
        rd_req = r; rd_addr = a; rd_word = w1; rd_postinc = $urandom; rd_near = a < 16'h2000 && $urandom;
        wr_req = w; wr_addr = b; wr_word = w2; wr_data = wd; wr_postinc = $urandom;
        wr_near = b < 16'h2000 && $urandom;
        if (r) begin
            {rg, ea} = dec(a, rpg);
            v = (rg == 3'h5) ? 16'h0000 : ea[15:0] ^ {ea[23:16], 8'hC3};
            rq.push_back({!(w1 && a[0]), !w1, rg, ea, w1 ? v : {8'h00, a[0] ? v[15:8] : v[7:0]}});
        end
        if (w) begin
            {rg, ea} = dec(b, wpg);
            wq.push_back({b != 16'h0032 && b != 16'h0034, rg != 3'h5 && !(w2 && b[0]), rg,
                          w2 ? 2'b11 : {b[0], !b[0]}, ea, w2 ? wd : {2{wd[7:0]}}});
            if (b == 16'h0032) rpg = wd[8:0];
            if (b == 16'h0034) wpg = {1'b0, wd[7:0]};
        end
    endtask
    always @(negedge mclk) begin
        if (rd_s2) begin
            d = dq.pop_front();
            if (d[17]) `CHK("rd_data", d[15:0], rd_data)
            if (d[17] && d[16]) `CHK("wreg_new", {wreg_old[15:8], d[7:0]}, wreg_new)
        end
        if (rd_s1) begin
            n = rq.pop_front();
            `CHK("rd_region", n[42:40], mem_rd_region)
            `CHK("rd_addr", n[39:16], mem_rd_addr)
            dq.push_back({n[44:43], n[15:0]});
        end
        if (wr_s1) begin
            m = wq.pop_front();
            if (m[46]) `CHK("mem_wr", m[45], mem_wr)
            if (m[46] && m[45]) `CHK("wr_region", m[44:42], mem_wr_region)
            if (m[46] && m[45]) `CHK("wr_lane", m[41:40], mem_wr_lane)
            if (m[46] && m[45]) `CHK("wr_addr", m[39:16], mem_wr_addr)
            if (m[46] && m[45]) `CHK("wdata", m[15:0], mem_wdata)
        end
        rd_s2 = rd_s1;
        rd_s1 = rd_req & rst_n;
        wr_s1 = wr_req & rst_n;
    end
    task stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        seed = $urandom(44);
        wreg_old = $urandom;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1;
        @(negedge mclk);
        `CHK("read page", 9'h001, window_read_page_reg)
        op(0, 16'h0000, 0, 1, 16'h0034, 1, 16'h01FF);
        op(0, 16'h0000, 0, 0, 16'h0000, 0, 16'h0000);
        @(negedge mclk);
        `CHK("write page", 9'h0FF, window_write_page_reg)
        foreach (pt[p]) begin
            op(0, 16'h0000, 0, 1, 16'h0032, 1, {7'h00, pt[p]});
            op(0, 16'h0000, 0, 0, 16'h0000, 0, 16'h0000);
            foreach (rt[i]) op(1, rt[i][15:0], rt[i][16], 1, wt[i][15:0], wt[i][16], $urandom);
        end
        repeat (300) begin
            rw = $urandom;
            ww = $urandom;
            ra = 16'h0800 + $urandom_range(16'h6FFF, 0);
            wa = 16'h0800 + $urandom_range(16'h6FFF, 0);
            op(1, {ra[15:1], ra[0] & !rw}, rw, 1, {wa[15:1], wa[0] & !ww}, ww, $urandom);
        end
        op(0, 16'h0000, 0, 0, 16'h0000, 0, 16'h0000);
        repeat (3) @(negedge mclk);
        @(posedge mclk);
        #1 ext_sign = 1;
        wreg_old = $urandom;
        @(posedge mclk);
        @(negedge mclk);
        `CHK("sign ext", {{8{wreg_old[7]}}, wreg_old[7:0]}, wreg_new)
        @(posedge mclk);
        #1 ext_sign = 0;
        ext_zero = 1;
        wreg_old = $urandom | 16'h8080;
        @(posedge mclk);
        @(negedge mclk);
        `CHK("zero ext", {8'h00, wreg_old[7:0]}, wreg_new)
        @(posedge mclk);
        #1 ext_zero = 0;
        stop_test;
    end
endmodule // tb
